// ===== hw/bcm_regs.vh
// constants of the boot copy master: bus codes, defaults, flag positions
`ifndef BCM_REGS_VH
`define BCM_REGS_VH

// transfer type codes; busy and sequential codes are never used
`define BCM_HTRANS_IDLE 2'h0
`define BCM_HTRANS_NONSEQ 2'h2

// word size and single burst codes
`define BCM_HSIZE_WORD 3'h2
`define BCM_HBURST_SINGLE 3'h0

// copy defaults: destination start, word count, flash source address
`define BCM_DST_ADDR_RST 32'h0000_0000
`define BCM_WORD_COUNT_RST 32'h0000_0800
`define BCM_SRC_ADDR_RST 24'h00_0000
`define BCM_FLASH_READ_CMD 8'h03

// address step between words in bytes
`define BCM_ADDR_STEP 32'h0000_0004

// positions of the bus error flags
`define BCM_ERR_RESP_BIT 0
`define BCM_ERR_VERIFY_BIT 1

// flash command frame length in bits and counter width
`define BCM_CMD_BITS 6'h20
`define BCM_CMD_CNT_W 6

// reset release synchroniser depth
`define BCM_RST_SYNC_W 2

`endif

// ===== hw/bcm_flash_tx.v
// serialiser that sends the flash read command frame, msb first
`timescale 1ns/100ps
`default_nettype none
`include "bcm_regs.vh"

module bcm_flash_tx (
  input wire mclk,
  input wire srst,
  input wire ce,
  input wire start,
  input wire [31:0] frame,
  input wire shift_en,
  output reg serial_out,
  output reg busy,
  output reg done
);

  reg [31:0] shift_reg;
  reg [`BCM_CMD_CNT_W-1:0] cnt_reg;

  always @(posedge mclk) begin
    if (srst) begin
      shift_reg <= 32'h0000_0000;
      cnt_reg <= {`BCM_CMD_CNT_W{1'b0}};
      serial_out <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy) begin
        // first bit goes out at once, the rest follow each shift tick
        serial_out <= frame[31];
        shift_reg <= {frame[30:0], 1'b0};
        cnt_reg <= `BCM_CMD_BITS - 6'h01;
        busy <= 1'b1;
      end else if (busy && shift_en) begin
        if (cnt_reg == {`BCM_CMD_CNT_W{1'b0}}) begin
          busy <= 1'b0;
          done <= 1'b1;
          serial_out <= 1'b0;
        end else begin
          serial_out <= shift_reg[31];
          shift_reg <= {shift_reg[30:0], 1'b0};
          cnt_reg <= cnt_reg - 6'h01;
        end
      end
    end
  end

endmodule // bcm_flash_tx
`default_nettype wire

// ===== hw/bcm_boot_copy.v
// boot copy engine: bus master that copies flash words into memory
//
// Functional notes
// - Everything runs on the single bus clock mclk.
// - Bus reset is active low, asserts asynchronously from po_reset_n and on a clock edge from srst, releases on a clock edge.
// - hwrite is high for write transfers and low for reads.
// - Transfer ends on hready high; read data good only if hresp stayed low.
// - htrans idles at 00 and is 10 for one address phase cycle.
// - Busy and sequential transfer codes are never driven.
// - hsize always carries the 32-bit word code.
// - hburst always carries the single transfer code.
// - hresp high flags a bus error and keeps the processor in reset.
// - Serial command data leaves toward the flash on flash_serial_out.
// - Error flag bit 0 on error response, bit 1 on read-back mismatch.
// - Processor reset stays low until a successful copy completes, or until the debug strap or a zero word count skips the copy.
`timescale 1ns/100ps
`default_nettype none
`include "bcm_regs.vh"

module bcm_boot_copy (
  input wire mclk,
  input wire srst,
  input wire ce,
  input wire po_reset_n,
  input wire sw_debug_mode,
  input wire [31:0] dst_addr,
  input wire [31:0] word_count,
  input wire [23:0] src_addr,
  input wire flash_shift_en,
  input wire word_valid,
  input wire [31:0] word_data,
  output reg word_ready,
  output wire flash_serial_out,
  output reg hresetn,
  output reg [31:0] haddr,
  output reg [31:0] hwdata,
  input wire [31:0] hrdata,
  output reg hwrite,
  input wire hready,
  output reg [1:0] htrans,
  output reg [2:0] hsize,
  output reg [2:0] hburst,
  input wire hresp,
  output reg [1:0] ahb_err,
  output reg cpu_reset_n,
  output reg copy_done
);

  // engine states; done and error are left only through a reset
  localparam [3:0] ST_WAIT = 4'h0;
  localparam [3:0] ST_CMD = 4'h1;
  localparam [3:0] ST_WORD = 4'h2;
  localparam [3:0] ST_WADDR = 4'h3;
  localparam [3:0] ST_WDATA = 4'h4;
  localparam [3:0] ST_VADDR = 4'h5;
  localparam [3:0] ST_VDATA = 4'h6;
  localparam [3:0] ST_DONE = 4'h7;
  localparam [3:0] ST_ERR = 4'h8;

  reg [`BCM_RST_SYNC_W-1:0] rst_sync_reg;
  reg dbg_meta_reg;
  reg dbg_sync_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [31:0] addr_reg;
  reg [31:0] left_reg;
  reg [31:0] first_reg;
  reg [31:0] first_addr_reg;
  reg first_pending_reg;
  reg resp_seen_reg;
  reg tx_start_reg;
  wire tx_busy;
  wire tx_done;
  wire bus_run;
  wire phase_err;
  wire tx_clear;

  // true in the cycles that carry a data phase of ours
  function data_phase;
    input [3:0] st;
    begin
      data_phase = (st == ST_WDATA) || (st == ST_VDATA);
    end
  endfunction

  // read-back compare, shared by the state machine and the flag logic
  function word_differs;
    input [31:0] got;
    input [31:0] want;
    begin
      word_differs = (got != want);
    end
  endfunction

  // async assertion from power-on, release ripples through the clocked stages
  always @(posedge mclk or negedge po_reset_n) begin
    if (!po_reset_n) begin
      rst_sync_reg <= {`BCM_RST_SYNC_W{1'b0}};
      hresetn <= 1'b0;
    end else if (srst) begin
      // srst pulls the bus reset too, but only on a clock edge
      rst_sync_reg <= {`BCM_RST_SYNC_W{1'b0}};
      hresetn <= 1'b0;
    end else if (ce) begin
      rst_sync_reg <= {rst_sync_reg[`BCM_RST_SYNC_W-2:0], 1'b1};
      hresetn <= rst_sync_reg[`BCM_RST_SYNC_W-1];
    end
  end

  assign bus_run = hresetn;

  // a bus reset cuts a command frame as well, so a restart never meets a
  // half-sent frame whose done pulse would skip the real command
  assign tx_clear = srst | ~bus_run;

  // debug strap comes from a pin, so it is synchronised before use
  always @(posedge mclk) begin
    if (srst) begin
      dbg_meta_reg <= 1'b0;
      dbg_sync_reg <= 1'b0;
    end else if (ce) begin
      dbg_meta_reg <= sw_debug_mode;
      dbg_sync_reg <= dbg_meta_reg;
    end
  end

  // an error reply is two cycles; its first cycle already has hresp high
  assign phase_err = resp_seen_reg |
    (hresp & data_phase(state_reg));

  // phases never overlap: a slower bus in exchange for a master that can
  // stop right after the first error reply with no transfer in flight
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_WAIT: begin
        if (bus_run) begin
          if (dbg_sync_reg)
            state_next = ST_DONE;
          else if (word_count == 32'h0000_0000)
            state_next = ST_DONE;
          else if (tx_busy)
            state_next = ST_WAIT;
          else
            state_next = ST_CMD;
        end
      end
      ST_CMD: begin
        if (tx_done)
          state_next = ST_WORD;
      end
      ST_WORD: begin
        if (word_valid && word_ready)
          state_next = ST_WADDR;
      end
      ST_WADDR: begin
        if (hready)
          state_next = ST_WDATA;
      end
      ST_WDATA: begin
        if (hready) begin
          if (phase_err)
            state_next = ST_ERR;
          else if (first_pending_reg)
            state_next = ST_VADDR;
          else if (left_reg == 32'h0000_0000)
            state_next = ST_DONE;
          else
            state_next = ST_WORD;
        end
      end
      ST_VADDR: begin
        if (hready)
          state_next = ST_VDATA;
      end
      ST_VDATA: begin
        // one read-back of the first word shows stuck data lines
        if (hready) begin
          if (phase_err || word_differs(hrdata, first_reg))
            state_next = ST_ERR;
          else if (left_reg == 32'h0000_0000)
            state_next = ST_DONE;
          else
            state_next = ST_WORD;
        end
      end
      ST_DONE: state_next = ST_DONE;
      ST_ERR: state_next = ST_ERR;
      default: state_next = ST_WAIT;
    endcase
  end

  always @(posedge mclk) begin
    if (srst || !bus_run) begin
      state_reg <= ST_WAIT;
      addr_reg <= `BCM_DST_ADDR_RST;
      left_reg <= `BCM_WORD_COUNT_RST;
      first_reg <= 32'h0000_0000;
      first_addr_reg <= `BCM_DST_ADDR_RST;
      first_pending_reg <= 1'b1;
      resp_seen_reg <= 1'b0;
      tx_start_reg <= 1'b0;
      word_ready <= 1'b0;
      haddr <= 32'h0000_0000;
      hwdata <= 32'h0000_0000;
      hwrite <= 1'b0;
      htrans <= `BCM_HTRANS_IDLE;
      hsize <= `BCM_HSIZE_WORD;
      hburst <= `BCM_HBURST_SINGLE;
      cpu_reset_n <= 1'b0;
      copy_done <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      tx_start_reg <= 1'b0;
      // only single word transfers exist, so these never move
      hsize <= `BCM_HSIZE_WORD;
      hburst <= `BCM_HBURST_SINGLE;
      case (state_reg)
        ST_WAIT: begin
          addr_reg <= dst_addr;
          first_addr_reg <= dst_addr;
          left_reg <= word_count;
          if (bus_run && state_next == ST_CMD)
            tx_start_reg <= 1'b1;
        end
        ST_CMD: begin
          if (tx_done)
            word_ready <= 1'b1;
        end
        ST_WORD: begin
          if (word_valid && word_ready) begin
            word_ready <= 1'b0;
            haddr <= addr_reg;
            hwrite <= 1'b1;
            htrans <= `BCM_HTRANS_NONSEQ;
            hwdata <= word_data;
            if (first_pending_reg)
              first_reg <= word_data;
            addr_reg <= addr_reg + `BCM_ADDR_STEP;
            left_reg <= left_reg - 32'h0000_0001;
          end
        end
        ST_WADDR, ST_VADDR: begin
          resp_seen_reg <= 1'b0;
          if (hready)
            htrans <= `BCM_HTRANS_IDLE;
        end
        ST_WDATA: begin
          if (hresp)
            resp_seen_reg <= 1'b1;
          if (hready && state_next == ST_VADDR) begin
            // read back the first word before streaming the rest
            first_pending_reg <= 1'b0;
            haddr <= first_addr_reg;
            hwrite <= 1'b0;
            htrans <= `BCM_HTRANS_NONSEQ;
          end
          if (hready && state_next == ST_WORD)
            word_ready <= 1'b1;
        end
        ST_VDATA: begin
          if (hresp)
            resp_seen_reg <= 1'b1;
          if (hready && state_next == ST_WORD)
            word_ready <= 1'b1;
        end
        ST_DONE: begin
          // a flag kept from before a bus reset still bars the release
          cpu_reset_n <= (ahb_err == 2'h0);
          copy_done <= 1'b1;
        end
        ST_ERR: begin
          // only a reset leaves this state, so the processor stays held
          cpu_reset_n <= 1'b0;
        end
        default: begin
          htrans <= `BCM_HTRANS_IDLE;
        end
      endcase
    end
  end

  // flags are sticky until srst; they survive a bus reset, one from po_reset_n included
  always @(posedge mclk) begin
    if (srst) begin
      ahb_err <= 2'h0;
    end else if (ce && bus_run) begin
      if (data_phase(state_reg) && hresp)
        ahb_err[`BCM_ERR_RESP_BIT] <= 1'b1;
      // a failed read sets only the response flag, never the verify flag
      if (state_reg == ST_VDATA && hready && !phase_err &&
          word_differs(hrdata, first_reg))
        ahb_err[`BCM_ERR_VERIFY_BIT] <= 1'b1;
    end
  end

  bcm_flash_tx u_flash_tx (
    .mclk(mclk),
    .srst(tx_clear),
    .ce(ce),
    .start(tx_start_reg),
    .frame({`BCM_FLASH_READ_CMD, src_addr}),
    .shift_en(flash_shift_en),
    .serial_out(flash_serial_out),
    .busy(tx_busy),
    .done(tx_done)
  );

endmodule // bcm_boot_copy
`default_nettype wire

// ===== tb/bcm_boot_copy_checker.sv
// assertion checker for the boot copy bus master
`timescale 1ns/100ps
`default_nettype none
`include "bcm_regs.vh"
module bcm_boot_copy_checker (
  input wire mclk,
  input wire srst,
  input wire hresetn,
  input wire [31:0] haddr,
  input wire [31:0] hwdata,
  input wire hwrite,
  input wire hready,
  input wire [1:0] htrans,
  input wire [2:0] hsize,
  input wire [2:0] hburst,
  input wire hresp,
  input wire [1:0] ahb_err,
  input wire cpu_reset_n,
  input wire copy_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic dph_reg;
  always_ff @(posedge mclk) begin
    if (srst || !hresetn) dph_reg <= 1'b0;
    else if (hready) dph_reg <= htrans == `BCM_HTRANS_NONSEQ;
  end
  // a wait state of our own data phase; phases never overlap here
  sequence s_stall;
    dph_reg && !hready;
  endsequence
  sequence s_err;
    dph_reg && hresp;
  endsequence
  a_htrans_code: assert property (
    htrans == `BCM_HTRANS_IDLE || htrans == `BCM_HTRANS_NONSEQ)
    else $error("bad htrans");
  a_hsize_word: assert property (hsize == `BCM_HSIZE_WORD)
    else $error("bad hsize");
  a_hburst_single: assert property (hburst == `BCM_HBURST_SINGLE)
    else $error("bad hburst");
  a_addr_hold: assert property (s_stall |=> htrans ==
    `BCM_HTRANS_IDLE && $stable(haddr) && $stable(hwrite) &&
    $stable(hwdata))
    else $error("data phase moved");
  a_nonseq_once: assert property (htrans == `BCM_HTRANS_NONSEQ
    && hready |=> htrans == `BCM_HTRANS_IDLE)
    else $error("second address phase");
  a_err_flag: assert property (s_err |-> ##[1:3] ahb_err[0])
    else $error("error not flagged");
  a_err_cpu: assert property (ahb_err != 2'h0 |-> !cpu_reset_n)
    else $error("cpu released on error");
  a_cpu_release: assert property ($rose(cpu_reset_n) |->
    copy_done && ahb_err == 2'h0)
    else $error("early cpu release");
  a_err_stop: assert property (ahb_err[0] |->
    htrans == `BCM_HTRANS_IDLE)
    else $error("transfer after error");
  a_reset_hold: assert property (!hresetn |=>
    htrans == `BCM_HTRANS_IDLE && !cpu_reset_n)
    else $error("engine ran in reset");
endmodule // bcm_boot_copy_checker
bind bcm_boot_copy bcm_boot_copy_checker chk_u (.mclk(mclk), .srst(srst),
  .hresetn(hresetn), .haddr(haddr), .hwdata(hwdata), .hwrite(hwrite),
  .hready(hready),
  .htrans(htrans), .hsize(hsize), .hburst(hburst), .hresp(hresp),
  .ahb_err(ahb_err), .cpu_reset_n(cpu_reset_n), .copy_done(copy_done));
`default_nettype wire

// ===== tb/bcm_ahb_mem.sv
// AHB-Lite memory partner with random waits and injected faults
`timescale 1ns/100ps
`default_nettype none
module bcm_ahb_mem (
  input wire mclk,
  input wire hresetn,
  input wire [31:0] haddr,
  input wire [31:0] hwdata,
  input wire hwrite,
  input wire [1:0] htrans,
  input wire err_en,
  input wire bad_rd,
  output logic hready,
  output logic hresp,
  output logic [31:0] hrdata
);
  logic [31:0] mem [0:255];
  logic [7:0] a_reg;
  logic w_reg, dph_reg;
  logic tgl_reg = 1'b0;
  integer mseed = 32'hC0F1;
  // outside a read data phase the bus toggles, so stale data never matches
  assign hrdata = (dph_reg && !w_reg && hready) ?
    mem[a_reg] ^ {32{bad_rd}} : {32{tgl_reg}};
  always @(posedge mclk) begin
    tgl_reg <= !tgl_reg;
    if (!hresetn) begin
      dph_reg <= 1'b0;
      hready <= 1'b1;
      hresp <= 1'b0;
    end else if (hready) begin
      if (dph_reg && w_reg && !hresp) mem[a_reg] <= hwdata;
      dph_reg <= htrans[1];
      a_reg <= haddr[9:2];
      w_reg <= hwrite;
      // single-bit response, two-cycle error form
      hresp <= htrans[1] && err_en;
      hready <= !(htrans[1] && (err_en || ($random(mseed) & 1)));
    end else hready <= 1'b1;
  end
endmodule // bcm_ahb_mem
`default_nettype wire

// ===== tb/test_bcm_boot_copy.sv
// self-checking bench of the boot copy master against a memory model
`timescale 1ns/100ps
`default_nettype none
`include "bcm_regs.vh"
module test_bcm_boot_copy;
  logic mclk = 1'b0, srst = 1'b1, po_reset_n = 1'b1, tick = 1'b0;
  logic wv = 1'b0, err_en = 1'b0, bad_rd = 1'b0, dph = 1'b0, dw = 1'b0;
  logic [31:0] wd = 32'h0, dst = 32'h0, cnt = 32'h1, da = 32'h0;
  logic [23:0] src = 24'h0;
  logic dbg = 1'b0;
  logic [63:0] expq [$];
  logic [63:0] e;
  integer n_fail = 0, check_count = 0, seed = 32'hC0F1;
  wire word_ready, fso, hresetn, hwrite, hready, hresp, cpu_reset_n;
  wire copy_done;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans, ahb_err;
  wire [2:0] hsize, hburst;
  always #2.5 mclk = ~mclk;
  bcm_boot_copy dut_u (.mclk(mclk), .srst(srst), .ce(1'b1),
    .po_reset_n(po_reset_n), .sw_debug_mode(dbg), .dst_addr(dst),
    .word_count(cnt), .src_addr(src), .flash_shift_en(tick),
    .word_valid(wv), .word_data(wd), .word_ready(word_ready),
    .flash_serial_out(fso), .hresetn(hresetn), .haddr(haddr),
    .hwdata(hwdata), .hrdata(hrdata), .hwrite(hwrite), .hready(hready),
    .htrans(htrans), .hsize(hsize), .hburst(hburst), .hresp(hresp),
    .ahb_err(ahb_err), .cpu_reset_n(cpu_reset_n), .copy_done(copy_done));
  bcm_ahb_mem mem_u (.mclk(mclk), .hresetn(hresetn), .haddr(haddr),
    .hwdata(hwdata), .hwrite(hwrite), .htrans(htrans), .err_en(err_en),
    .bad_rd(bad_rd), .hready(hready), .hresp(hresp), .hrdata(hrdata));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // completed write data phases are matched against the words handed in
  always @(posedge mclk) begin
    if (hready === 1'b1) begin
      if (dph && dw && hresp === 1'b0 && expq.size() > 0) begin
        e = expq.pop_front();
        chk(da, e[63:32]);
        chk(hwdata, e[31:0]);
      end
      dph <= htrans === `BCM_HTRANS_NONSEQ;
      da <= haddr;
      dw <= hwrite;
    end
  end
  task copy(input integer nw);
    integer i, k;
    logic [31:0] fr;
    fr = {`BCM_FLASH_READ_CMD, src};
    k = 0;
    while (hresetn !== 1'b1 && k < 100) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 100) n_fail++;
    repeat (3) @(negedge mclk);
    for (i = 31; i >= 0; i--) begin
      chk(fso, fr[i]);
      tick = 1'b1;
      @(negedge mclk);
      tick = 1'b0;
      @(negedge mclk);
    end
    // valid stays up between words; only data changes after each take
    for (i = 0; i < nw; i++) begin
      wd = $random(seed);
      wv = 1'b1;
      expq.push_back({dst + `BCM_ADDR_STEP * i, wd});
      k = 0;
      // ready seen at a falling edge: the next rising edge takes the word
      while (word_ready !== 1'b1 && k < 300) begin
        @(negedge mclk);
        k++;
      end
      if (k >= 300) n_fail++;
      @(negedge mclk);
    end
    wv = 1'b0;
  endtask
  initial begin
    integer s;
    for (s = 0; s < 4; s++) begin
      err_en = s == 1;
      bad_rd = s == 2;
      dbg = s == 3;
      dst = $random(seed) & 32'h0000_03C0;
      src = $random(seed);
      cnt = 32'h1 + ($random(seed) & 32'h3);
      srst = 1'b1;
      repeat (16) @(negedge mclk);
      srst = 1'b0;
      if (s == 0) begin
        wait (hresetn === 1'b1);
        @(negedge mclk);
        po_reset_n = 1'b0;
        #1 chk(hresetn, 0);
        @(negedge mclk);
        po_reset_n = 1'b1;
        @(negedge mclk);
        chk(hresetn, 0);
        repeat (2) @(negedge mclk);
        chk(hresetn, 1);
      end
      // the debug strap skips the copy: no frame and no words follow
      if (s < 3) copy(s == 0 ? cnt : 1);
      repeat (40) @(negedge mclk);
      if (s == 3) chk(fso, 0);
      chk({ahb_err, cpu_reset_n, copy_done},
        s == 1 ? 4'h4 : s == 2 ? 4'h8 : 4'h3);
      if (s == 0) chk(expq.size(), 0);
      expq.delete();
    end
    results();
  end
  initial begin
    #50000;
    n_fail++;
    results();
  end
endmodule // test_bcm_boot_copy
`default_nettype wire
